/* File: hw/tcb_regs.svh */
/*
  Register offsets, field positions and fixed counts of the trace capture buffer.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
`ifndef TCB_REGS_SVH
`define TCB_REGS_SVH

`define OFF_CTRL 32'h0000_0000
`define OFF_DEPTH 32'h0000_0004
`define OFF_SEGLG 32'h0000_0008
`define OFF_TEN 32'h0000_000c
`define OFF_DEN 32'h0000_0010
`define OFF_COND 32'h0000_0014
`define OFF_STATUS 32'h0000_0018
`define OFF_RDSEL 32'h0000_001c
`define OFF_SAMPLE 32'h0000_0020
`define OFF_TRIGPOS 32'h0000_0024

`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_TPOS_LO 2
`define CTRL_CONT 4
`define CTRL_SEGM 5

`define STAT_BUSY 0
`define STAT_TRIG 1
`define STAT_DONE 2
`define STAT_SEG_LO 8

`define COND_W 3
`define SEGLG_W 4
`define POST_LATE_SHIFT 3
`define POST_CENTER_SHIFT 1

`endif

/* File: hw/tcb_pkg.sv */
/*
  Types shared by the trace capture buffer and its trigger evaluator.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tcb_pkg;

  // APB request from the master, carried as one bundle.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // Per-signal basic trigger condition.
  typedef enum logic [2:0] {
    COND_ANY = 3'h0,
    COND_LOW = 3'h1,
    COND_HIGH = 3'h2,
    COND_FALL = 3'h3,
    COND_RISE = 3'h4,
    COND_EDGE = 3'h5
  } cond_t;

  // Where the trigger sample sits in a buffer or segment.
  typedef enum logic [1:0] {
    TPOS_EARLY = 2'h0,
    TPOS_CENTER = 2'h1,
    TPOS_LATE = 2'h2
  } tpos_t;

  // Capture controller states.
  typedef enum logic [1:0] {
    CAP_IDLE = 2'h0,
    CAP_ARMED = 2'h1,
    CAP_POST = 2'h2,
    CAP_DONE = 2'h3
  } cap_state_t;

endpackage : tcb_pkg

/* File: hw/trig_eval.sv */
/*
  Basic trigger evaluator: one condition per tapped signal, all ANDed.
  Assumes the taps are synchronous to pclk; edges compare against the previous cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tcb_regs.svh"

module trig_eval
  import tcb_pkg::*;
#(
  parameter int NSIG = 8
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NSIG-1:0] taps,
  input wire logic [NSIG-1:0] ten,
  input wire logic [`COND_W*NSIG-1:0] cond,
  output logic hit
);

  typedef struct packed {
    logic [NSIG-1:0] prev;
  } state_t;

  state_t q;
  state_t d;
  logic [NSIG-1:0] ok;
  logic [NSIG-1:0] rise_m;
  logic [NSIG-1:0] high_m;
  logic [NSIG-1:0] low_m;

  // six conditions
  // One matcher per signal; a signal with its trigger enable off always agrees.
  for (genvar i = 0; i < NSIG; i++)
  begin : g_sig
    cond_t c;
    assign c = cond_t'(cond[`COND_W*i +: `COND_W]);
    assign rise_m[i] = ten[i] && (c == COND_RISE);
    assign high_m[i] = ten[i] && (c == COND_HIGH);
    assign low_m[i] = ten[i] && (c == COND_LOW);
    always_comb
    begin
      unique case (c)
        COND_LOW: ok[i] = !ten[i] || !taps[i];
        COND_HIGH: ok[i] = !ten[i] || taps[i];
        COND_FALL: ok[i] = !ten[i] || (q.prev[i] && !taps[i]);
        COND_RISE: ok[i] = !ten[i] || (!q.prev[i] && taps[i]);
        COND_EDGE: ok[i] = !ten[i] || (q.prev[i] != taps[i]);
        default: ok[i] = 1'b1; // Don't care and the two unused codes.
      endcase
    end
  end

  assign hit = &ok;

  // The previous sample is kept every cycle so edges are seen from the first clock.
  always_comb
  begin
    d = q;
    d.prev = taps;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  property p_rise_needs_edge;
    @(posedge pclk) disable iff (!presetn)
      hit |-> ((taps & ~q.prev & rise_m) == rise_m);
  endproperty
  a_rise_needs_edge: assert property (p_rise_needs_edge)
    else $error("Trigger fired without a rising edge on a rise-enabled tap.");

  property p_levels_all_hold;
    @(posedge pclk) disable iff (!presetn)
      hit |-> (((taps & high_m) == high_m) && ((taps & low_m) == '0));
  endproperty
  a_levels_all_hold: assert property (p_levels_all_hold)
    else $error("Trigger fired while a level condition did not hold.");

endmodule : trig_eval

`default_nettype wire

/* File: hw/trace_capture_buffer.sv */
/*
  Trace capture controller with APB register access and on-chip sample memory.
  Assumes taps are synchronous to pclk and software programs it before start.
*/
// How it works
// - Runtime depth register selects 0 up to 128K samples per tap.
// - Without segmented mode the whole depth is one circular buffer; reset default.
// - Before a trigger writes continue, wrapping over the oldest sample.
// - After trigger, store the post-trigger count set by position, then stop.
// - Position early, centre or late sets post-trigger share of the buffer.
// - Continuous option keeps capturing until software writes stop.
// - Segmented mode splits depth into a power-of-two count of equal segments.
// - Segments let one run record many triggered occurrences without restart.
// - Each tap triggers on don't care, low, high, fall, rise or either edge.
// - Trigger fires only when all enabled tap conditions hold together.
// - Each tap has separate trigger and data enables.
`timescale 1ns/1ps
`default_nettype none
`include "tcb_regs.svh"

module trace_capture_buffer
  import tcb_pkg::*;
#(
  parameter int NSIG = 8,
  parameter int MAX_DEPTH = 131072,
  parameter int SGW = 10
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire apb_req_t apb,
  input wire logic [NSIG-1:0] taps,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy,
  output logic done
);

  localparam int CW = $clog2(MAX_DEPTH) + 1;
  localparam int AW = CW - 1;
  localparam logic [`SEGLG_W-1:0] SGL = `SEGLG_W'(SGW);

  typedef struct packed {
    cap_state_t st;
    logic [CW-1:0] wptr;
    logic [CW-1:0] base;
    logic [CW-1:0] cnt;
    logic [SGW-1:0] seg;
    logic trigd;
    logic busy;
    logic done;
    tpos_t tpos;
    logic cont;
    logic segm;
    logic [CW-1:0] depth;
    logic [`SEGLG_W-1:0] seglg;
    logic [NSIG-1:0] ten;
    logic [NSIG-1:0] den;
    logic [`COND_W*NSIG-1:0] cond;
    logic [31:0] rdsel;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } state_t;

  state_t q;
  state_t d;
  logic hit;
  logic [NSIG-1:0] mem [MAX_DEPTH];
  logic [CW-1:0] tmem [2**SGW];
  logic [`SEGLG_W-1:0] lg_eff;
  logic [CW-1:0] seg_len;
  logic [CW-1:0] plen;
  logic [CW-1:0] wptr_nx;
  logic [CW-1:0] waddr;
  logic [CW-1:0] cnt_nx;
  logic [SGW-1:0] seg_last;
  logic storing;
  logic trig_now;
  logic end_seg;
  logic wr_en;
  logic rd_start;
  logic known;
  logic [31:0] rd;

  trig_eval #(.NSIG(NSIG)) u_trig (
    .pclk(pclk),
    .presetn(presetn),
    .taps(taps),
    .ten(q.ten),
    .cond(q.cond),
    .hit(hit)
  );

  // equal segments
  // Segment count is 2**seglg, capped at 2**SGW; circular mode is simply one segment of full depth.
  always_comb
  begin
    lg_eff = q.segm ? ((q.seglg > SGL) ? SGL : q.seglg) : '0;
    seg_len = q.depth >> lg_eff;
    seg_last = SGW'((32'd1 << lg_eff) - 32'd1);
  end

  // trigger position
  // Early keeps most samples after the trigger, late keeps most before it.
  always_comb
  begin
    unique case (q.tpos)
      TPOS_EARLY: plen = seg_len - (seg_len >> `POST_LATE_SHIFT);
      TPOS_LATE: plen = seg_len >> `POST_LATE_SHIFT;
      default: plen = seg_len >> `POST_CENTER_SHIFT;
    endcase
  end

  assign wptr_nx = (q.wptr + CW'(1) >= seg_len) ? '0 : q.wptr + CW'(1);
  assign waddr = q.base + q.wptr;
  assign storing = (q.st == CAP_ARMED) || (q.st == CAP_POST);
  assign trig_now = (q.st == CAP_ARMED) && hit;
  // The trigger sample counts as the first post-trigger sample.
  assign cnt_nx = (q.st == CAP_ARMED) ? CW'(1) : q.cnt + CW'(1);
  assign end_seg = (trig_now || q.st == CAP_POST) && !q.cont && (cnt_nx >= plen);

  // APB: a write lands on the edge where pready is seen high; reads are staged
  // one cycle earlier so prdata can come from a flop.
  assign rd_start = apb.psel && apb.penable && !q.rdy;
  assign wr_en = apb.psel && apb.penable && q.rdy && apb.pwrite && !q.err;

  // Read decode; an unmapped address answers with pslverr.
  always_comb
  begin
    rd = '0;
    known = 1'b1;
    unique case (apb.paddr)
      `OFF_CTRL:
      begin
        rd[`CTRL_TPOS_LO +: 2] = q.tpos;
        rd[`CTRL_CONT] = q.cont;
        rd[`CTRL_SEGM] = q.segm;
      end
      `OFF_DEPTH: rd[CW-1:0] = q.depth;
      `OFF_SEGLG: rd[`SEGLG_W-1:0] = q.seglg;
      `OFF_TEN: rd[NSIG-1:0] = q.ten;
      `OFF_DEN: rd[NSIG-1:0] = q.den;
      `OFF_COND: rd[`COND_W*NSIG-1:0] = q.cond;
      `OFF_STATUS:
      begin
        rd[`STAT_BUSY] = q.busy;
        rd[`STAT_TRIG] = q.trigd;
        rd[`STAT_DONE] = q.done;
        rd[`STAT_SEG_LO +: SGW] = q.seg;
      end
      `OFF_RDSEL: rd = q.rdsel;
      `OFF_SAMPLE: rd[NSIG-1:0] = mem[q.rdsel[AW-1:0]];
      `OFF_TRIGPOS: rd[CW-1:0] = tmem[q.rdsel[SGW-1:0]];
      default: known = 1'b0;
    endcase
  end

  // Next-state for bus, configuration and capture sequencing.
  always_comb
  begin
    d = q;
    d.rdy = rd_start;
    // The error flag lives only for the answer cycle, so pslverr comes straight from it.
    d.err = rd_start && !known;
    if (rd_start)
    begin
      d.rdata = apb.pwrite ? '0 : rd;
    end
    if (storing)
      d.wptr = wptr_nx;
    if (trig_now)
    begin
      d.st = CAP_POST;
      d.trigd = 1'b1;
    end
    if (storing && (trig_now || q.st == CAP_POST))
      d.cnt = cnt_nx;
    if (end_seg)
    begin
      if (q.seg != seg_last)
      begin
        d.st = CAP_ARMED;
        d.seg = q.seg + SGW'(1);
        d.base = q.base + seg_len;
        d.wptr = '0;
        d.cnt = '0;
      end
      else
        d.st = CAP_DONE;
    end
    if (wr_en)
    begin
      unique case (apb.paddr)
        `OFF_CTRL:
        begin
          d.tpos = tpos_t'(apb.pwdata[`CTRL_TPOS_LO +: 2]);
          d.cont = apb.pwdata[`CTRL_CONT];
          d.segm = apb.pwdata[`CTRL_SEGM];
          if (apb.pwdata[`CTRL_STOP] && storing)
            d.st = CAP_DONE;
          else if (apb.pwdata[`CTRL_START])
          begin
            d.st = (q.depth == '0) ? CAP_DONE : CAP_ARMED;
            d.wptr = '0;
            d.base = '0;
            d.cnt = '0;
            d.seg = '0;
            d.trigd = 1'b0;
          end
        end
        // The whole word is compared so a large request cannot alias to a small depth.
        `OFF_DEPTH: d.depth = (apb.pwdata > 32'(MAX_DEPTH)) ? CW'(MAX_DEPTH)
                                                            : apb.pwdata[CW-1:0];
        `OFF_SEGLG: d.seglg = apb.pwdata[`SEGLG_W-1:0];
        `OFF_TEN: d.ten = apb.pwdata[NSIG-1:0];
        `OFF_DEN: d.den = apb.pwdata[NSIG-1:0];
        `OFF_COND: d.cond = apb.pwdata[`COND_W*NSIG-1:0];
        `OFF_RDSEL: d.rdsel = apb.pwdata;
        default: d.rdsel = q.rdsel;
      endcase
    end
    d.busy = (d.st == CAP_ARMED) || (d.st == CAP_POST);
    d.done = (d.st == CAP_DONE);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.depth <= CW'(MAX_DEPTH);
      q.ten <= '1;
      q.den <= '1;
    end
    else
      q <= d;
  end

  // data enable
  // Memory has no reset; data-disabled taps are stored as zero.
  always_ff @(posedge pclk)
  begin
    if (storing)
      mem[waddr[AW-1:0]] <= taps & q.den;
    if (trig_now)
      tmem[q.seg] <= q.wptr;
  end

  assign prdata = q.rdata;
  assign pready = q.rdy;
  assign pslverr = q.err;
  assign busy = q.busy;
  assign done = q.done;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_wrap_advance;
    (q.st == CAP_ARMED) && !hit && !wr_en |=> q.wptr == $past(wptr_nx);
  endproperty
  a_wrap_advance: assert property (p_wrap_advance)
    else $error("Write pointer did not advance or wrap before trigger.");

  property p_post_stop;
    (q.st == CAP_POST) && !q.cont && (cnt_nx >= plen) && !q.segm && !wr_en
      |=> q.st == CAP_DONE ##1 (q.st == CAP_DONE);
  endproperty
  a_post_stop: assert property (p_post_stop)
    else $error("Capture did not stop after the post-trigger count.");

  property p_center_len;
    (q.tpos == TPOS_CENTER) |-> ((seg_len - plen) - plen) <= CW'(1);
  endproperty
  a_center_len: assert property (p_center_len)
    else $error("Centre position does not split the segment in half.");

  property p_cont_runs;
    (q.st == CAP_POST) && q.cont && !wr_en |=> q.st == CAP_POST;
  endproperty
  a_cont_runs: assert property (p_cont_runs)
    else $error("Continuous capture ended without a stop.");

  property p_wptr_in_seg;
    storing |-> (q.wptr < seg_len) && (waddr < q.depth);
  endproperty
  a_wptr_in_seg: assert property (p_wptr_in_seg)
    else $error("Write address left its segment.");

  sequence s_seg_full;
    (q.st == CAP_POST) && end_seg && (q.seg != seg_last) && !wr_en;
  endsequence
  sequence s_rearmed;
    (q.st == CAP_ARMED) && (q.wptr == '0) && (q.cnt == '0);
  endsequence
  property p_seg_next;
    s_seg_full |=> s_rearmed and (q.seg == $past(q.seg) + SGW'(1));
  endproperty
  a_seg_next: assert property (p_seg_next)
    else $error("Full segment did not re-arm the next one.");

  property p_trig_recorded;
    trig_now && !wr_en |=> (tmem[$past(q.seg)] == $past(q.wptr)) && q.trigd;
  endproperty
  a_trig_recorded: assert property (p_trig_recorded)
    else $error("Trigger write position was not recorded.");

  property p_apb_one_wait;
    rd_start |=> pready ##1 !pready;
  endproperty
  a_apb_one_wait: assert property (p_apb_one_wait)
    else $error("APB answer was not exactly one wait state.");

endmodule : trace_capture_buffer

`default_nettype wire

/* File: dv/tap_source.sv */
/*
  Model of the observed user logic: an 8-bit count on the taps.
  Assumes the bench pulses restart to bring the count back to zero.
*/
`timescale 1ns/1ps
`default_nettype none

module tap_source #(
  parameter int NSIG = 8
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  output logic [NSIG-1:0] taps
);
  // A plain count makes every stored sample predictable from its neighbours.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      taps <= '0;
    else if (restart)
      taps <= '0;
    else
      taps <= taps + 1'b1;
  end
endmodule : tap_source
`default_nettype wire

/* File: dv/tb.sv */
/*
  Self-checking bench for the trace capture buffer, driven over APB.
  Assumes tap_source feeds the taps with a count restarted before each run.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tcb_regs.svh"

module tb
  import tcb_pkg::*;
;
  localparam int MAXD = 256;
  logic pclk;
  logic presetn;
  logic restart;
  apb_req_t req;
  logic [7:0] taps;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic busy;
  logic done;
  logic [31:0] rd;
  logic err;
  logic [31:0] seed;
  logic [7:0] den;
  int fail_count;
  int samples_checked;
  logic [31:0] ra [7] = '{`OFF_CTRL, `OFF_DEPTH, `OFF_SEGLG, `OFF_TEN, `OFF_DEN, `OFF_COND,
    `OFF_RDSEL};
  logic [31:0] rv [7] = '{32'h0, MAXD, 32'h0, 32'hff, 32'hff, 32'h0, 32'h0};

  // A small depth keeps every run short.
  trace_capture_buffer #(.NSIG(8), .MAX_DEPTH(MAXD), .SGW(10)) uut (
    .pclk(pclk), .presetn(presetn), .apb(req), .taps(taps), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy), .done(done));
  tap_source #(.NSIG(8)) src (.pclk(pclk), .presetn(presetn), .restart(restart), .taps(taps));

  // Clock with a 5 ns period.
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic int post_len(int len, int p);
    return p == 0 ? len - len / 8 : p == 1 ? len / 2 : len / 8;
  endfunction : post_len

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    @(posedge pclk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= addr;
    req.pwdata <= wd;
    @(posedge pclk);
    req.penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic arm(input logic [31:0] depth, sl, ten, dn, cond, ctrl);
    apb(1'b1, `OFF_DEPTH, depth);
    apb(1'b1, `OFF_SEGLG, sl);
    apb(1'b1, `OFF_TEN, ten);
    apb(1'b1, `OFF_DEN, dn);
    apb(1'b1, `OFF_COND, cond);
    @(posedge pclk);
    restart <= 1'b1;
    @(posedge pclk);
    restart <= 1'b0;
    apb(1'b1, `OFF_CTRL, ctrl);
  endtask : arm

  task automatic wait_done();
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge pclk);
      if (done === 1'b1)
        break;
    end
    chk("done", 1, done);
  endtask : wait_done

  // Walks a whole segment around its trigger; the count makes each sample known.
  task automatic chk_buf(input int seg, len, post, input logic [7:0] trig);
    int tp;
    apb(1'b1, `OFF_RDSEL, seg);
    apb(1'b0, `OFF_TRIGPOS, 0);
    tp = int'(rd);
    for (int k = post - len; k < post; k++)
    begin
      apb(1'b1, `OFF_RDSEL, 32'(seg * len + (tp + k + len) % len));
      apb(1'b0, `OFF_SAMPLE, 0);
      chk("sample", 32'((trig + k) & den), rd);
    end
  endtask : chk_buf

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  // Main sequence.
  initial
  begin
    presetn = 1'b0;
    restart = 1'b0;
    req = '0;
    fail_count = 0;
    samples_checked = 0;
    seed = 32'd5629;
    den = 8'hff;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, ra[i], 0);
      chk("reset value", rv[i], rd);
    end
    apb(1'b0, 32'h0000_0040, 0);
    chk("slverr", 1, err);
    apb(1'b1, `OFF_DEPTH, 32'h0003_ffff);
    apb(1'b0, `OFF_DEPTH, 0);
    chk("depth clamp", MAXD, rd);
    $display("test reset done");
    // Circular runs at each position; tap 6 is left out of the trigger.
    for (int p = 0; p < 3; p++)
    begin
      den = 8'hff >> (xs() % 3);
      arm(16, 0, 32'hbf, den, 32'h0029_2002, 32'(1 + 4 * p));
      wait_done();
      chk_buf(0, 16, post_len(16, p), 8'h31);
    end
    $display("test circular done");
    // Falling and either-edge conditions on tap 5, late position.
    den = 8'hff;
    for (int e = 0; e < 2; e++)
    begin
      arm(16, 0, 32'hff, 32'hff, e == 0 ? 32'h0001_8000 : 32'h0002_8000, 32'h9);
      wait_done();
      chk_buf(0, 16, 2, e == 0 ? 8'h40 : 8'h20);
    end
    $display("test edge done");
    // Four segments, each caught by a later rising edge of tap 4.
    arm(64, 2, 32'hff, 32'hff, 32'h0000_4000, 32'h21);
    wait_done();
    apb(1'b0, `OFF_STATUS, 0);
    chk("status", (1 << `STAT_TRIG) | (1 << `STAT_DONE) | (3 << `STAT_SEG_LO), rd);
    for (int s = 0; s < 4; s++)
      chk_buf(s, 16, 14, 8'(8'h10 + 8'h20 * s));
    $display("test segmented done");
    // Continuous capture passes its trigger and runs until stopped.
    arm(16, 0, 32'hbf, 32'hff, 32'h0029_2002, 32'h11);
    repeat (100) @(posedge pclk);
    chk("cont busy", 1, busy);
    chk("cont done", 0, done);
    apb(1'b1, `OFF_CTRL, 32'h2);
    for (int i = 0; i < 10 && busy !== 1'b0; i++)
      @(posedge pclk);
    chk("stop busy", 0, busy);
    // A zero depth ends at once.
    arm(0, 0, 32'hff, 32'hff, 0, 32'h1);
    for (int i = 0; i < 10 && done !== 1'b1; i++)
      @(posedge pclk);
    chk("zero depth", 1, done);
    $display("test continuous done");
    end_of_test();
  end

  // Watchdog against a hung handshake.
  initial
  begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
